// ==== hw/gpio_irq_modem_select_ctrl.sv ====
`timescale 1ns/10ps
// Contract
// - One interrupt enable bit per pin; 0 disables, 1 enables.
// - Enables of a group in modem function have no effect.
// - Writing 1 to control bit 3 resets the whole device; the read data register keeps its value.
// - Software reset bit clears itself once that reset completes.
// - Control bit 2 selects pins 3..0 as GPIO or channel B modem lines.
// - Control bit 1 selects pins 7..4 as GPIO or channel A modem lines.
// - Without latching, pin interrupt clears if input returns before read.
// - With latching, interrupt holds and state bit keeps the causing level.
// - Direction bit 0 input, 1 output; resets to all inputs.
// - State read gives pin levels; write drives output pins; resets to ones.
module gpio_irq_modem_select_ctrl (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire gpio_ctrl_pkg::reg_req_s reg_req_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [7:0] pin_in_i,
  output logic [7:0] pin_out_o,
  output logic [7:0] pin_oe_o,
  input wire logic terminal_ready_a_i,
  input wire logic terminal_ready_b_i,
  output gpio_ctrl_pkg::modem_in_s modem_a_o,
  output gpio_ctrl_pkg::modem_in_s modem_b_o,
  output logic pin_irq_o,
  output logic soft_reset_o
);

  logic [7:0] pin_direction_register;
  logic [7:0] pin_level_register;
  logic [7:0] pin_interrupt_enable;
  logic [3:0] pin_control;
  logic [7:0] last_read;
  logic [7:0] latched_level;
  logic [7:0] latched_pend;

  wire sw_rst = pin_control[gpio_ctrl_pkg::CTRL_SWRST_BIT];
  wire latch_en = pin_control[gpio_ctrl_pkg::CTRL_LATCH_BIT];
  wire modem_a = pin_control[gpio_ctrl_pkg::CTRL_MODEM_A_BIT];
  wire modem_b = pin_control[gpio_ctrl_pkg::CTRL_MODEM_B_BIT];
  wire [7:0] gpio_mode = {{4{~modem_a}}, {4{~modem_b}}};

  wire wr_dir = reg_req_i.wr && (reg_req_i.addr == gpio_ctrl_pkg::DIR_OFFSET);
  wire wr_level = reg_req_i.wr && (reg_req_i.addr == gpio_ctrl_pkg::LEVEL_OFFSET);
  wire wr_irq_en = reg_req_i.wr && (reg_req_i.addr == gpio_ctrl_pkg::IRQ_EN_OFFSET);
  wire wr_ctrl = reg_req_i.wr && (reg_req_i.addr == gpio_ctrl_pkg::CTRL_OFFSET);
  wire rd_level = reg_req_i.rd && (reg_req_i.addr == gpio_ctrl_pkg::LEVEL_OFFSET);

  // Watched pins: enabled, in GPIO function and configured as input
  // Only inputs are watched; an output pin never interrupts
  wire [7:0] pin_is_input = ~pin_direction_register;
  wire [7:0] watch = pin_interrupt_enable & gpio_mode & pin_is_input;
  wire [7:0] differs = (pin_in_i ^ last_read) & watch;
  wire [7:0] state_view;
  wire [7:0] pending;

  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_pin
      // Latched pins show the captured level until read
      assign state_view[i] = latched_pend[i] ? latched_level[i] : pin_in_i[i];
      // Unlatched pins simply compare, so a return to the old level drops it
      assign pending[i] = latch_en ? latched_pend[i] : differs[i];
      // Held while pending; a read releases it
      wire keep_pend = latched_pend[i] && !rd_level;
      // Captured level follows the pin while nothing is pending or in a state read cycle
      wire capture = !latched_pend[i] || rd_level;
      always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          latched_pend[i] <= 1'b0;
        end else if (sw_rst) begin
          latched_pend[i] <= 1'b0;
        end else if (keep_pend) begin
          latched_pend[i] <= watch[i] && latch_en;
        end else begin
          // A change in the read cycle itself sets no pending bit; last_read takes the new level instead
          latched_pend[i] <= differs[i] && latch_en && !rd_level;
        end
      end

      always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          latched_level[i] <= 1'b0;
        end else if (sw_rst) begin
          latched_level[i] <= 1'b0;
        end else if (capture) begin
          latched_level[i] <= pin_in_i[i];
        end
      end
    end
  endgenerate

  // One-hot read select; unmapped offsets select nothing and read zero
  wire rd_sel_dir = (reg_req_i.addr == gpio_ctrl_pkg::DIR_OFFSET);
  wire rd_sel_level = (reg_req_i.addr == gpio_ctrl_pkg::LEVEL_OFFSET);
  wire rd_sel_irq_en = (reg_req_i.addr == gpio_ctrl_pkg::IRQ_EN_OFFSET);
  wire rd_sel_ctrl = (reg_req_i.addr == gpio_ctrl_pkg::CTRL_OFFSET);
  wire [7:0] ctrl_view = {4'h0, pin_control};
  wire [7:0] rd_mux =
    ({8{rd_sel_dir}} & pin_direction_register) |
    ({8{rd_sel_level}} & state_view) |
    ({8{rd_sel_irq_en}} & pin_interrupt_enable) |
    ({8{rd_sel_ctrl}} & ctrl_view);

  // Modem function routing per group
  wire [7:0] next_out;
  wire [7:0] next_oe;
  assign next_out[7:4] = modem_a ?
    {2'b00, terminal_ready_a_i, 1'b0} : pin_level_register[7:4];
  assign next_out[3:0] = modem_b ?
    {2'b00, terminal_ready_b_i, 1'b0} : pin_level_register[3:0];
  assign next_oe[7:4] = modem_a ? 4'h2 : pin_direction_register[7:4];
  assign next_oe[3:0] = modem_b ? 4'h2 : pin_direction_register[3:0];

  // Each modem group is one nibble of the pins
  wire [3:0] group_a = pin_in_i[7:4];
  wire [3:0] group_b = pin_in_i[3:0];

  // Inactive modem inputs read high, as the lines are active low
  assign modem_a_o.ring_indicate =
    modem_a ? group_a[gpio_ctrl_pkg::MODEM_RING_INDICATE_POS] : 1'b1;
  assign modem_a_o.carrier_detect =
    modem_a ? group_a[gpio_ctrl_pkg::MODEM_CARRIER_DETECT_POS] : 1'b1;
  assign modem_a_o.set_ready =
    modem_a ? group_a[gpio_ctrl_pkg::MODEM_SET_READY_POS] : 1'b1;
  assign modem_b_o.ring_indicate =
    modem_b ? group_b[gpio_ctrl_pkg::MODEM_RING_INDICATE_POS] : 1'b1;
  assign modem_b_o.carrier_detect =
    modem_b ? group_b[gpio_ctrl_pkg::MODEM_CARRIER_DETECT_POS] : 1'b1;
  assign modem_b_o.set_ready =
    modem_b ? group_b[gpio_ctrl_pkg::MODEM_SET_READY_POS] : 1'b1;

  assign pin_irq_o = |pending;
  assign soft_reset_o = sw_rst;

  // Software reset lasts one cycle and puts every register back except the read data and the pad registers, which follow a cycle later
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_direction_register <= gpio_ctrl_pkg::DIR_RESET;
    end else if (sw_rst) begin
      pin_direction_register <= gpio_ctrl_pkg::DIR_RESET;
    end else if (wr_dir) begin
      pin_direction_register <= reg_req_i.wdata;
    end
  end

  // Written value reaches only pins set as outputs
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_level_register <= gpio_ctrl_pkg::LEVEL_RESET;
    end else if (sw_rst) begin
      pin_level_register <= gpio_ctrl_pkg::LEVEL_RESET;
    end else if (wr_level) begin
      pin_level_register <= reg_req_i.wdata;
    end
  end

  // Enables of modem groups are kept but masked in watch
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_interrupt_enable <= gpio_ctrl_pkg::IRQ_EN_RESET;
    end else if (sw_rst) begin
      pin_interrupt_enable <= gpio_ctrl_pkg::IRQ_EN_RESET;
    end else if (wr_irq_en) begin
      pin_interrupt_enable <= reg_req_i.wdata;
    end
  end

  // Reserved bits 7:4 are not stored and read as zero
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_control <= gpio_ctrl_pkg::CTRL_RESET;
    end else if (sw_rst) begin
      pin_control <= gpio_ctrl_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      pin_control <= reg_req_i.wdata[3:0];
    end
  end

  // Reference level for change detection
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      last_read <= gpio_ctrl_pkg::LEVEL_RESET;
    end else if (sw_rst) begin
      last_read <= gpio_ctrl_pkg::LEVEL_RESET;
    end else if (rd_level) begin
      last_read <= state_view;
    end
  end

  // Read data holds until the next read
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_req_i.rd) begin
      reg_rdata_o <= rd_mux;
    end
  end

  // Pad drive is registered so decode glitches never reach a pin
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_out_o <= gpio_ctrl_pkg::LEVEL_RESET;
    end else begin
      pin_out_o <= next_out;
    end
  end

  // Modem groups override the direction register
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_oe_o <= gpio_ctrl_pkg::DIR_RESET;
    end else begin
      pin_oe_o <= next_oe;
    end
  end

endmodule : gpio_irq_modem_select_ctrl

// ==== hw/gpio_ctrl_pkg.sv ====
package gpio_ctrl_pkg;

  localparam logic [7:0] DIR_OFFSET = 8'h0A;
  localparam logic [7:0] LEVEL_OFFSET = 8'h0B;
  localparam logic [7:0] IRQ_EN_OFFSET = 8'h0C;
  localparam logic [7:0] CTRL_OFFSET = 8'h0E;

  localparam logic [7:0] DIR_RESET = 8'h00;
  localparam logic [7:0] LEVEL_RESET = 8'hFF;
  localparam logic [7:0] IRQ_EN_RESET = 8'h00;
  localparam logic [3:0] CTRL_RESET = 4'h0;

  localparam int CTRL_LATCH_BIT = 0;
  localparam int CTRL_MODEM_A_BIT = 1;
  localparam int CTRL_MODEM_B_BIT = 2;
  localparam int CTRL_SWRST_BIT = 3;

  // Position of each modem line inside its four-pin group
  localparam int MODEM_SET_READY_POS = 0;
  localparam int MODEM_TERMINAL_READY_POS = 1;
  localparam int MODEM_CARRIER_DETECT_POS = 2;
  localparam int MODEM_RING_INDICATE_POS = 3;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic ring_indicate;
    logic carrier_detect;
    logic set_ready;
  } modem_in_s;

endpackage : gpio_ctrl_pkg

// ==== test/gpio_pad_model.sv ====
`timescale 1ns/10ps
// Pads seen from the board: a driven pin reads back its own drive
module gpio_pad_model (
  input wire logic [7:0] drive_i,
  input wire logic [7:0] oe_i,
  input wire logic [7:0] ext_i,
  output logic [7:0] level_o
);
  assign level_o = (oe_i & drive_i) | (~oe_i & ext_i);
endmodule : gpio_pad_model

// ==== test/gpio_irq_modem_select_ctrl_assertions.sv ====
`timescale 1ns/10ps
module gpio_ctrl_chk (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire gpio_ctrl_pkg::reg_req_s reg_req_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [7:0] pin_in_i,
  input wire logic [7:0] pin_out_o,
  input wire logic [7:0] pin_oe_o,
  input wire gpio_ctrl_pkg::modem_in_s modem_a_o,
  input wire gpio_ctrl_pkg::modem_in_s modem_b_o,
  input wire logic pin_irq_o,
  input wire logic soft_reset_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  // Writes in the soft reset cycle are lost
  wire wr_ok = reg_req_i.wr && !soft_reset_o;
  property p_swrst; wr_ok && reg_req_i.addr == 8'h0E && reg_req_i.wdata[3] |=> soft_reset_o;
  endproperty
  a_swrst: assert property (p_swrst) else $error("no soft reset pulse");
  property p_swrst_once; soft_reset_o |=> !soft_reset_o; endproperty
  a_swrst_once: assert property (p_swrst_once) else $error("reset bit stuck");
  property p_irq_rst; soft_reset_o |=> !pin_irq_o; endproperty
  a_irq_rst: assert property (p_irq_rst) else $error("irq after soft reset");
  property p_dir; wr_ok && reg_req_i.addr == 8'h0A |=> ##1 pin_oe_o == $past(reg_req_i.wdata, 2);
  endproperty
  a_dir: assert property (p_dir) else $error("direction not applied");
  property p_out; wr_ok && reg_req_i.addr == 8'h0B |=> ##1 pin_out_o == $past(reg_req_i.wdata, 2);
  endproperty
  a_out: assert property (p_out) else $error("drive not applied");
  property p_mdm_a; modem_a_o != 3'h7 |-> modem_a_o == {pin_in_i[7], pin_in_i[6], pin_in_i[4]};
  endproperty
  a_mdm_a: assert property (p_mdm_a) else $error("modem a lines wrong");
  property p_mdm_b; modem_b_o != 3'h7 |-> modem_b_o == {pin_in_i[3], pin_in_i[2], pin_in_i[0]};
  endproperty
  a_mdm_b: assert property (p_mdm_b) else $error("modem b lines wrong");
  property p_hold; !reg_req_i.rd && !soft_reset_o |=> $stable(reg_rdata_o); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
endmodule : gpio_ctrl_chk
bind gpio_irq_modem_select_ctrl gpio_ctrl_chk u_chk (.ref_clk_i, .rstn_i, .reg_req_i,
  .reg_rdata_o, .pin_in_i, .pin_out_o, .pin_oe_o, .modem_a_o, .modem_b_o, .pin_irq_o,
  .soft_reset_o);

// ==== test/gpio_irq_modem_select_ctrl_tb_top.sv ====
`timescale 1ns/10ps
module gpio_irq_modem_select_ctrl_tb_top;
  logic ref_clk_i = 0;
  logic rstn_i = 0;
  gpio_ctrl_pkg::reg_req_s req = '0;
  logic [7:0] rdata, pin_in, pin_out, pin_oe;
  logic [7:0] ext = 8'hFF;
  gpio_ctrl_pkg::modem_in_s mdm_a, mdm_b;
  logic irq, swrst;
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;
  always #20 ref_clk_i = ~ref_clk_i;
  gpio_pad_model pads (.drive_i(pin_out), .oe_i(pin_oe), .ext_i(ext), .level_o(pin_in));
  gpio_irq_modem_select_ctrl dut (.ref_clk_i, .rstn_i, .reg_req_i(req), .reg_rdata_o(rdata),
    .pin_in_i(pin_in), .pin_out_o(pin_out), .pin_oe_o(pin_oe), .terminal_ready_a_i(1'b1),
    .terminal_ready_b_i(1'b0), .modem_a_o(mdm_a), .modem_b_o(mdm_b), .pin_irq_o(irq),
    .soft_reset_o(swrst));
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i) #1 req = '{a, 1'b1, 1'b0, d};
    @(posedge ref_clk_i) #1 req.wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk_i) #1 req = '{a, 1'b0, 1'b1, 8'h00};
    @(posedge ref_clk_i) #1 req.rd = 1'b0;
    cmp(rdata, exp);
  endtask : rd
  task automatic pad(input logic [7:0] v);
    @(posedge ref_clk_i) #1 ext = v;
  endtask : pad
  task automatic t_reset;
    rd(8'h0A, 8'h00);
    rd(8'h0B, 8'hFF);
    rd(8'h0C, 8'h00);
    rd(8'h0E, 8'h00);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_dir;
    wr(8'h0A, 8'h0F);
    wr(8'h0B, 8'hA5);
    rd(8'h0B, 8'hF5);
    cmp(pin_oe, 8'h0F);
    wr(8'h0A, 8'h00);
    $display("t_dir done");
  endtask : t_dir
  task automatic t_irq;
    rd(8'h0B, 8'hFF);
    wr(8'h0C, 8'h01);
    pad(8'hFE);
    pad(8'hFE);
    cmp(irq, 8'h01);
    pad(8'hFF);
    pad(8'hFF);
    cmp(irq, 8'h00);
    pad(8'hFD);
    pad(8'hFD);
    cmp(irq, 8'h00);
    wr(8'h0C, 8'h02);
    wr(8'h0E, 8'h01);
    pad(8'hFF);
    pad(8'hFF);
    cmp(irq, 8'h01);
    rd(8'h0B, 8'hFD);
    rd(8'h0B, 8'hFF);
    cmp(irq, 8'h00);
    wr(8'h0E, 8'h00);
    $display("t_irq done");
  endtask : t_irq
  task automatic t_modem;
    wr(8'h0E, 8'h06);
    wr(8'h0C, 8'hFF);
    pad(8'h5E);
    pad(8'h5E);
    cmp(mdm_a, 8'h03);
    cmp(mdm_b, 8'h06);
    cmp(irq, 8'h00);
    $display("t_modem done");
  endtask : t_modem
  task automatic t_swrst;
    wr(8'h0E, 8'h08);
    cmp(swrst, 8'h01);
    rd(8'h0C, 8'h00);
    rd(8'h0E, 8'h00);
    cmp(pin_out, 8'hFF);
    $display("t_swrst done");
  endtask : t_swrst
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  // Whole run needs well under 200 cycles
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      end_of_test();
    end
  end
  initial begin
    repeat (12) @(posedge ref_clk_i);
    #1 rstn_i = 1'b1;
    t_reset();
    t_dir();
    t_irq();
    t_modem();
    t_swrst();
    end_of_test();
  end
endmodule : gpio_irq_modem_select_ctrl_tb_top
